// file: rtl/seq_consts.vh
// Register offsets, field positions, reset values and command encodings of the command sequencer.
`ifndef SEQ_CONSTS_VH
`define SEQ_CONSTS_VH
`define ADDR_CONTROL      8'h00
`define ADDR_COUNT        8'h04
`define ADDR_CHECKSUM     8'h08
`define ADDR_TIMEOUT      8'h0C
`define ADDR_STATUS       8'h10
`define ADDR_MEM_ADDR     8'h14
`define ADDR_MEM_DATA     8'h18
`define ADDR_TRIGGER      8'h1C
`define ADDR_SEQ_INFO0    8'h20
`define ADDR_IRQ_FLAGS    8'h30
`define ADDR_IRQ_MASK     8'h34
`define CTRL_ENABLE_BIT   0
`define CTRL_PAUSE_BIT    1
`define CTRL_PWD_LSB      8
`define CTRL_PWD_MSB      15
`define CTRL_ORDER_LSB    16
`define CTRL_ORDER_MSB    23
`define CTRL_NSEQ_LSB     24
`define CTRL_NSEQ_MSB     25
`define CTRL_GPIO_BIT     28
`define CTRL_WAKE_BIT     29
`define CHECKSUM_SEED     8'h01
`define CHECKSUM_POLY     8'h07
`define INFO_LEN_LSB      16
`define INFO_LEN_MSB      26
`define INFO_START_MSB    10
`define CMD_WRITE_BIT     31
`define CMD_TIMEOUT_BIT   30
`define CMD_ADDR_LSB      24
`define CMD_ADDR_MSB      30
`define IRQ_END           0
`define IRQ_TO_DONE       1
`define IRQ_TO_ERROR      2
`endif

// file: rtl/afe_command_sequencer.v
// Command sequencer: stores up to four command sequences and executes them one at a time.
//
// Behaviour
// [R1] Four stored sequences, only one runs.
// [R2] Sequences run in host-configured order.
// [R3] Six kilobytes of command memory.
// [R4] Start from wake timer, host, GPIO.
// [R5] Sequential write or wait, never branch.
// [R6] No read path into registers.
// [R7] Enable bit starts, zero disables; the code needs a trigger, wake or GPIO start while enable is set.
// [R8] Write first, then post-write delay cycles.
// [R9] No post-write delay after timer commands.
// [R10] Pause freezes all sequencer activity.
// [R11] Register reads still served while paused.
// [R12] Counter increments per executed command.
// [R13] Any write to counter clears it.
// [R14] CRC-8 with polynomial x8+x2+x+1.
// [R15] One command per cycle, readable next.
// [R16] Counter write reseeds the checksum.
// [R17] Checksum read-only, seed 0x01.
// [R18] Individually maskable interrupt sources.
// [R19] Write command: MSB one, address bits 8:2.
// [R20] Write command writes only bits 23:0.
// [R21] Wait resumes when counter reaches zero.
// [R22] Timer unit is one clock period.
// [R23] Resume after pause with state intact.
// [R24] Checksum MSB first, no reflection.
`timescale 1ns/1ps
`include "seq_consts.vh"

module afe_command_sequencer #(
  parameter MEM_WORDS = 1536,
  parameter MEM_AW    = 11
) (
  // Clock, reset and enable.
  input  wire        MCLK,
  input  wire        RST_N,
  input  wire        CLK_EN,
  // Register port.
  input  wire [7:0]  ADDR,
  input  wire [31:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [31:0] RDATA,
  // Start sources from pins.
  input  wire        WAKE_TIMER,
  input  wire        GPIO_TRIG,
  // Mapped register write port.
  output reg         REG_WE,
  output reg  [15:0] REG_ADDR,
  output reg  [23:0] REG_WDATA,
  // Status.
  output reg         BUSY,
  output reg         IRQ
);

  // Engine states, one-hot. The engine walks IDLE, then NEXT, which loads the
  // next sequence of the configured order when the current one is used up.
  // It then walks FETCH, EXEC and DELAY once per command and returns to NEXT.
  // NEXT goes back to IDLE once the last configured slot has run dry.
  // Only NEXT loads the program counter, from a sequence start, and FETCH
  // moves it by one, so the command stream cannot branch.
  localparam S_IDLE  = 5'b00001;
  localparam S_FETCH = 5'b00010;
  localparam S_EXEC  = 5'b00100;
  localparam S_DELAY = 5'b01000;
  localparam S_NEXT  = 5'b10000;


  // Command memory and host-visible configuration.
  // The memory is written only through the data port and read only by the
  // engine, one word per fetch.
  reg  [31:0]       mem [0:MEM_WORDS-1];
  reg  [31:0]       control;
  reg  [31:0]       seq_info [0:3];
  reg  [MEM_AW-1:0] mem_wr_addr;
  reg  [4:0]        state;
  reg  [MEM_AW-1:0] pc;
  reg  [10:0]       remaining;
  reg  [1:0]        slot;
  reg               last_slot;
  reg  [31:0]       cmd;
  reg  [29:0]       wait_count;
  reg  [29:0]       timeout_count;
  reg               timeout_run;
  reg  [31:0]       count;
  reg  [7:0]        checksum;
  reg  [2:0]        irq_flags;
  reg  [2:0]        irq_mask;
  reg               wake_s1;
  reg               wake_s2;
  reg               wake_d;
  reg               gpio_s1;
  reg               gpio_s2;
  reg               gpio_d;
  reg               host_start;
  reg  [7:0]        next_checksum;
  reg  [2:0]        irq_set;
  integer           i;
  integer           j;

  // Decoded control fields and start sources.
  // Pause gates every state change of the engine and the timers except the
  // abort on a cleared enable, but not the register port, so the host can inspect a frozen sequence.
  // The wake input starts on a rising edge, the GPIO input on any toggle.
  wire enable     = control[`CTRL_ENABLE_BIT];
  wire [1:0] nseq = control[`CTRL_NSEQ_MSB:`CTRL_NSEQ_LSB];
  wire paused     = control[`CTRL_PAUSE_BIT];
  wire run        = CLK_EN && !paused;                            // see [R10]
  wire wake_edge  = wake_s2 && !wake_d && control[`CTRL_WAKE_BIT];
  wire gpio_edge  = (gpio_s2 != gpio_d) && control[`CTRL_GPIO_BIT];
  wire start      = enable && (host_start || wake_edge || gpio_edge); // see [R4]
  wire [1:0] order_sel = control[`CTRL_ORDER_LSB + 2*slot +: 2]; // see [R2]
  wire [31:0] info     = seq_info[order_sel];                   // see [R1]
  wire count_wr   = WR && ADDR == `ADDR_COUNT;
  wire [7:0] pwd  = control[`CTRL_PWD_MSB:`CTRL_PWD_LSB];
  // The run ends when the last configured slot has no commands left.
  // The slot counter alone cannot tell this, since it wraps after four loads.
  wire run_end    = enable && run && state == S_NEXT && remaining == 11'h000 && last_slot;

  // CRC-8 absorbing one 32-bit command, most significant bit first.
  // The whole word is folded in one cycle so the host sees the new value
  // straight after the command that changed it.
  // There is no reflection and no final inversion.
  always @* begin
    next_checksum = checksum;
    for (i = 31; i >= 0; i = i - 1) begin
      if (next_checksum[7] ^ cmd[i]) begin                      // see [R24]
        next_checksum = {next_checksum[6:0], 1'b0} ^ `CHECKSUM_POLY; // see [R14]
      end else begin
        next_checksum = {next_checksum[6:0], 1'b0};
      end
    end
  end

  // Command memory is written by the host only; the sequencer only reads it.
  // The write address auto-increments so a sequence can be streamed in.
  // Sequences may overlap in memory; nothing warns about it.
  always @(posedge MCLK) begin
    if (CLK_EN && WR && ADDR == `ADDR_MEM_DATA) begin
      mem[mem_wr_addr] <= WDATA;                                // see [R3]
    end
  end

  // Two-stage synchronisers for the start pins, plus one more stage each
  // for edge detection. The reset values match the idle low level of the
  // pins so that no false start follows reset.
  always @(posedge MCLK) begin
    if (!RST_N) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_d  <= 1'b0;
      gpio_s1 <= 1'b0;
      gpio_s2 <= 1'b0;
      gpio_d  <= 1'b0;
    end else if (CLK_EN) begin
      wake_s1 <= WAKE_TIMER;
      wake_s2 <= wake_s1;
      wake_d  <= wake_s2;
      gpio_s1 <= GPIO_TRIG;
      gpio_s2 <= gpio_s1;
      gpio_d  <= gpio_s2;
    end
  end

  // Register reads are served regardless of pause.
  // Read data stand for exactly one cycle after the strobe and are zero
  // otherwise, so a late sample shows up as zero rather than stale data.
  always @(posedge MCLK) begin
    if (!RST_N) begin
      RDATA <= 32'h00000000;
    end else if (CLK_EN) begin
      if (RD) begin                                             // see [R11]
        case (ADDR)
          `ADDR_CONTROL:   RDATA <= control;
          `ADDR_COUNT:     RDATA <= count;
          `ADDR_CHECKSUM:  RDATA <= {24'h000000, checksum};     // see [R15]
          `ADDR_TIMEOUT:   RDATA <= {2'b00, timeout_count};
          `ADDR_STATUS:    RDATA <= {27'h0000000, state};
          `ADDR_MEM_ADDR:  RDATA <= {{(32-MEM_AW){1'b0}}, mem_wr_addr};
          `ADDR_SEQ_INFO0: RDATA <= seq_info[0];
          8'h24:           RDATA <= seq_info[1];
          8'h28:           RDATA <= seq_info[2];
          8'h2C:           RDATA <= seq_info[3];
          `ADDR_IRQ_FLAGS: RDATA <= {29'h00000000, irq_flags};
          `ADDR_IRQ_MASK:  RDATA <= {29'h00000000, irq_mask};
          default:         RDATA <= 32'h00000000;
        endcase
      end else begin
        RDATA <= 32'h00000000;
      end
    end
  end

  // Host register writes.
  // A write to the trigger offset raises a one-cycle start request.
  // At the end of a run the hardware clears the enable bit itself; a host
  // write in the same cycle takes priority over that clear.
  always @(posedge MCLK) begin
    if (!RST_N) begin
      control     <= 32'h00000000;
      mem_wr_addr <= {MEM_AW{1'b0}};
      host_start  <= 1'b0;
      irq_mask    <= 3'b000;
      for (j = 0; j < 4; j = j + 1) begin
        seq_info[j] <= 32'h00000000;
      end
    end else if (CLK_EN) begin
      host_start <= WR && ADDR == `ADDR_TRIGGER;
      if (WR) begin
        case (ADDR)
          `ADDR_CONTROL:   control <= WDATA;                    // see [R7]
          `ADDR_MEM_ADDR:  mem_wr_addr <= WDATA[MEM_AW-1:0];
          `ADDR_MEM_DATA:  mem_wr_addr <= mem_wr_addr + 1'b1;
          `ADDR_SEQ_INFO0: seq_info[0] <= WDATA;
          8'h24:           seq_info[1] <= WDATA;
          8'h28:           seq_info[2] <= WDATA;
          8'h2C:           seq_info[3] <= WDATA;
          `ADDR_IRQ_MASK:  irq_mask <= WDATA[2:0];              // see [R18]
          default:         ;
        endcase
      end else if (run_end) begin
        control[`CTRL_ENABLE_BIT] <= 1'b0;
      end
    end
  end

  // Sequencer engine.
  // A write command pulses the mapped register port for one cycle and then
  // holds for the post-write delay. A wait command holds for its own count.
  // A timeout command starts the independent timer and holds for nothing.
  // A hold of N takes N+1 cycles in DELAY, since the zero test takes one.
  // Clearing enable aborts at once; pause keeps every count where it is so
  // the run resumes with the next unexecuted command.
  // The engine never reads back what it writes.
  always @(posedge MCLK) begin
    if (!RST_N) begin
      state      <= S_IDLE;
      pc         <= {MEM_AW{1'b0}};
      remaining  <= 11'h000;
      slot       <= 2'b00;
      last_slot  <= 1'b0;
      cmd        <= 32'h00000000;
      wait_count <= 30'h00000000;
      REG_WE     <= 1'b0;
      REG_ADDR   <= 16'h0000;
      REG_WDATA  <= 24'h000000;
      BUSY       <= 1'b0;
    end else if (CLK_EN) begin
      REG_WE <= 1'b0;
      BUSY   <= state != S_IDLE;
      if (!enable) begin
        state <= S_IDLE;                                        // see [R7]
      end else if (run) begin                                   // see [R23]
        case (state)
          S_IDLE: begin
            if (start) begin
              slot      <= 2'b00;
              last_slot <= 1'b0;
              state     <= S_NEXT;
              remaining <= 11'h000;
            end
          end
          S_NEXT: begin
            if (remaining != 11'h000) begin
              state <= S_FETCH;
            end else if (!last_slot) begin
              pc        <= info[MEM_AW-1:0];
              remaining <= info[`INFO_LEN_MSB:`INFO_LEN_LSB];
              slot      <= slot + 1'b1;
              last_slot <= slot == nseq;
            end else begin
              state <= S_IDLE;
            end
          end
          S_FETCH: begin
            cmd       <= mem[pc];                               // see [R5]
            pc        <= pc + 1'b1;
            remaining <= remaining - 1'b1;
            state     <= S_EXEC;
          end
          S_EXEC: begin
            if (cmd[`CMD_WRITE_BIT]) begin                      // see [R19]
              REG_WE     <= 1'b1;                               // see [R6]
              REG_ADDR   <= {7'h00, cmd[`CMD_ADDR_MSB:`CMD_ADDR_LSB], 2'b00};
              REG_WDATA  <= cmd[23:0];                          // see [R20]
              wait_count <= {22'h000000, pwd};                  // see [R8]
            end else if (cmd[`CMD_TIMEOUT_BIT]) begin
              wait_count <= 30'h00000000;                       // see [R9]
            end else begin
              wait_count <= cmd[29:0];                          // see [R22]
            end
            state <= S_DELAY;
          end
          S_DELAY: begin
            if (wait_count == 30'h00000000) begin               // see [R21]
              state <= S_NEXT;
            end else begin
              wait_count <= wait_count - 1'b1;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // Counter, checksum and timeout timer.
  // A host write to the counter clears it and reseeds the checksum, even
  // while paused, and wins over an execution in the same cycle.
  // The timeout timer runs beside the engine and only stops on abort or
  // when it reaches zero.
  always @(posedge MCLK) begin
    if (!RST_N) begin
      count         <= 32'h00000000;
      checksum      <= `CHECKSUM_SEED;                          // see [R17]
      timeout_count <= 30'h00000000;
      timeout_run   <= 1'b0;
    end else if (CLK_EN) begin
      if (count_wr) begin
        count    <= 32'h00000000;                               // see [R13]
        checksum <= `CHECKSUM_SEED;                             // see [R16]
      end else if (run && enable && state == S_EXEC) begin
        count    <= count + 1'b1;                               // see [R12]
        checksum <= next_checksum;                              // see [R15]
      end
      if (!enable) begin
        timeout_run   <= 1'b0;
        timeout_count <= 30'h00000000;
      end else if (run && state == S_EXEC && !cmd[`CMD_WRITE_BIT] && cmd[`CMD_TIMEOUT_BIT]) begin
        timeout_run   <= 1'b1;
        timeout_count <= cmd[29:0];
      end else if (run && timeout_run) begin
        if (timeout_count == 30'h00000000) begin
          timeout_run <= 1'b0;
        end else begin
          timeout_count <= timeout_count - 1'b1;
        end
      end
    end
  end

  // Sticky interrupt flags; a new event wins over a clear in the same cycle.
  always @* begin
    irq_set = 3'b000;
    irq_set[`IRQ_END] = run_end;
    irq_set[`IRQ_TO_DONE]  = run && timeout_run && timeout_count == 30'h00000000;
    irq_set[`IRQ_TO_ERROR] = irq_set[`IRQ_TO_DONE] && state != S_IDLE;
  end

  // Flags are cleared by writing ones; the line is the masked OR of them.
  // The line follows the flags one cycle later since it is registered.
  always @(posedge MCLK) begin
    if (!RST_N) begin
      irq_flags <= 3'b000;
      IRQ       <= 1'b0;
    end else if (CLK_EN) begin
      if (WR && ADDR == `ADDR_IRQ_FLAGS) begin
        irq_flags <= (irq_flags & ~WDATA[2:0]) | irq_set;
      end else begin
        irq_flags <= irq_flags | irq_set;
      end
      IRQ <= |(irq_flags & irq_mask);                           // see [R18]
    end
  end

endmodule // afe_command_sequencer

// file: testbench/seq_checker_asserts.sv
// Port assertions for the command sequencer.
`timescale 1ns/1ps
module seq_checker (
  // Clock, reset and register port.
  input wire        MCLK,
  input wire        RST_N,
  input wire        CLK_EN,
  input wire [7:0]  ADDR,
  input wire [31:0] WDATA,
  input wire        WR,
  input wire        RD,
  input wire [31:0] RDATA,
  // Engine outputs.
  input wire        REG_WE,
  input wire [15:0] REG_ADDR,
  input wire        BUSY
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_clr(a);
    WR && ADDR == 8'h04 ##1 RD && ADDR == a && !BUSY;
  endsequence
  property p_idle; CLK_EN && !RD |=> RDATA == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("rdata off slot");
  property p_gap; REG_WE |=> !REG_WE [*2]; endproperty
  a_gap: assert property (p_gap) else $error("writes too close");
  property p_addr; REG_WE |-> REG_ADDR[15:9] == 7'h00 && REG_ADDR[1:0] == 2'h0; endproperty
  a_addr: assert property (p_addr) else $error("bad target address");
  property p_cnt; s_clr(8'h04) |=> RDATA == 32'h0; endproperty
  a_cnt: assert property (p_cnt) else $error("count not cleared");
  property p_seed; s_clr(8'h08) |=> RDATA == 32'h01; endproperty
  a_seed: assert property (p_seed) else $error("checksum not reseeded");
  property p_crcw; RD && ADDR == 8'h08 |=> RDATA[31:8] == 24'h0; endproperty
  a_crcw: assert property (p_crcw) else $error("checksum too wide");
  property p_pause; WR && ADDR == 8'h00 && WDATA[1:0] == 2'h3 |=> ##2 !REG_WE [*6]; endproperty
  a_pause: assert property (p_pause) else $error("write while paused");
  property p_off; WR && ADDR == 8'h00 && !WDATA[0] |-> ##4 !BUSY; endproperty
  a_off: assert property (p_off) else $error("busy after disable");
endmodule // seq_checker

bind afe_command_sequencer seq_checker u_seq_checker (.MCLK(MCLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .BUSY(BUSY));

// file: testbench/reg_target.sv
// Model of the mapped register bank that receives sequencer writes.
`timescale 1ns/1ps
module reg_target (
  // Write port from the sequencer.
  input  wire        clk,
  input  wire        we,
  input  wire [15:0] addr,
  input  wire [23:0] wdata,
  // What the bench observes.
  output reg         hit,
  output reg  [15:0] gap,
  output reg  [39:0] word,
  output reg  [15:0] writes
);
  reg [15:0] ticks;
  initial begin
    hit = 1'b0;
    ticks = 16'h0000;
    writes = 16'h0000;
  end
  // Gap is the distance in cycles between the last two write pulses.
  always @(posedge clk) begin
    hit <= we;
    ticks <= we ? 16'h0001 : ticks + 16'h0001;
    if (we) begin
      gap <= ticks;
      word <= {addr, wdata};
      writes <= writes + 16'h0001;
    end
  end
endmodule // reg_target

// file: testbench/testbench.sv
// Self-checking bench for the command sequencer.
`timescale 1ns/1ps
module testbench;
  reg         MCLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0, WAKE_TIMER = 1'b0, GPIO_TRIG = 1'b0;
  reg  [7:0]  ADDR = 8'h00;
  reg  [31:0] WDATA = 32'h0, seed = 32'hD623ADDA;
  wire [31:0] RDATA;
  wire        REG_WE, BUSY, IRQ, hit;
  wire [15:0] REG_ADDR, gap, writes;
  wire [23:0] REG_WDATA;
  wire [39:0] word;
  reg  [7:0]  crc_e;
  reg  [55:0] e;
  reg  [63:0] rq [$];
  reg  [55:0] wq [$];
  reg         rd_d = 1'b0;
  integer     failures = 0, n_checks = 0, i;
  always #50 MCLK = ~MCLK;
  afe_command_sequencer u_afe_command_sequencer (.MCLK(MCLK), .RST_N(RST_N), .CLK_EN(1'b1), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .WAKE_TIMER(WAKE_TIMER), .GPIO_TRIG(GPIO_TRIG),
    .REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .BUSY(BUSY), .IRQ(IRQ));
  reg_target u_reg_target (.clk(MCLK), .we(REG_WE), .addr(REG_ADDR), .wdata(REG_WDATA),
    .hit(hit), .gap(gap), .word(word), .writes(writes));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [7:0] crc(input [7:0] c, input [31:0] d);
    integer k;
    begin
      crc = c;
      for (k = 31; k >= 0; k = k - 1)
        crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ d[k]) ? 8'h07 : 8'h00);
    end
  endfunction
  task check(input [63:0] seen, input [63:0] want);
    begin
      n_checks = n_checks + 1;
      if (seen !== want) begin
        failures = failures + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      RD <= 1'b0;
      @(posedge MCLK);
    end
  endtask
  task rd(input [7:0] a, input [31:0] x);
    begin
      rq.push_back(x);
      ADDR <= a;
      RD <= 1'b1;
      WR <= 1'b0;
      @(posedge MCLK);
    end
  endtask
  task cycles(input integer n);
    begin
      WR <= 1'b0;
      RD <= 1'b0;
      repeat (n) @(posedge MCLK);
    end
  endtask
  task done;
    begin
      cycles(4);
      for (i = 0; i < 3000 && BUSY !== 1'b0; i = i + 1)
        @(posedge MCLK);
    end
  endtask
  task upto(input [15:0] n);
    begin
      cycles(1);
      for (i = 0; i < 500 && writes < n; i = i + 1)
        @(posedge MCLK);
    end
  endtask
  // Loads one command and notes what it should produce; g of zero leaves the gap unchecked.
  task ld(input [31:0] c, input [15:0] g);
    begin
      wr(8'h18, c);
      crc_e = crc(crc_e, c);
      if (c[31])
        wq.push_back({g, 7'h00, c[30:24], 2'h0, c[23:0]});
    end
  endtask
  task lw(input [15:0] g);
    begin
      seed = xs(seed);
      ld({1'b1, seed[30:0]}, g);
    end
  endtask
  task clr;
    begin
      seed = xs(seed);
      wr(8'h04, seed);
      rd(8'h08, 32'h01);
      wr(8'h04, seed);
      rd(8'h04, 32'h0);
      crc_e = 8'h01;
    end
  endtask
  always @(posedge MCLK) begin
    rd_d <= RD;
    if (rd_d)
      check(RDATA, rq.pop_front());
    if (hit) begin
      e = wq.pop_front();
      if (e[55:40] != 16'h0)
        check(gap, e[55:40]);
      check(word, e[39:0]);
    end
  end
  // A full run needs well under a thousand cycles.
  initial begin
    #500000;
    failures = failures + 1;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge MCLK);
    RST_N <= 1'b1;
    rd(8'h00, 32'h0);
    wr(8'h08, 32'hFF);
    rd(8'h08, 32'h01);
    rd(8'h40, 32'h0);
    clr;
    wr(8'h14, 32'h10);
    lw(16'h0);
    lw(16'h6);
    ld(32'h5, 16'h0);
    lw(16'hF);
    ld(32'h40000003, 16'h0);
    lw(16'hA);
    wr(8'h14, 32'h0);
    lw(16'h0);
    lw(16'h6);
    wr(8'h20, 32'h0002_0000);
    wr(8'h24, 32'h0006_0010);
    wr(8'h00, 32'h0101_0201);
    wr(8'h1C, 32'h1);
    done;
    rd(8'h04, 32'h8);
    rd(8'h08, {24'h0, crc_e});
    rd(8'h00, 32'h0101_0200);
    rd(8'h30, 32'h7);
    wr(8'h34, 32'h1);
    cycles(3);
    check(IRQ, 1'b1);
    wr(8'h30, 32'h7);
    cycles(3);
    check(IRQ, 1'b0);
    clr;
    wr(8'h14, 32'h20);
    lw(16'h0);
    lw(16'h0);
    lw(16'h2C);
    wr(8'h28, 32'h0003_0020);
    wr(8'h00, 32'h1002_2801);
    GPIO_TRIG <= 1'b1;
    upto(16'h7);
    wr(8'h00, 32'h1002_2803);
    cycles(60);
    check(writes, 16'h7);
    rd(8'h04, 32'h1);
    wr(8'h00, 32'h1002_2801);
    done;
    rd(8'h04, 32'h3);
    rd(8'h08, {24'h0, crc_e});
    clr;
    wr(8'h14, 32'h30);
    lw(16'h0);
    ld(32'h64, 16'h0);
    wr(8'h2C, 32'h0002_0030);
    wr(8'h00, 32'h2003_2801);
    WAKE_TIMER <= 1'b1;
    upto(16'hA);
    wr(8'h00, 32'h0);
    cycles(60);
    check(writes, 16'hA);
    check(BUSY, 1'b0);
    complete_run;
  end
endmodule // testbench
